// file: common/vfl_defs.svh
// Offsets, field positions, reset values and codes for the vector fault unit
`ifndef VFL_DEFS_SVH
`define VFL_DEFS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define VFL_TOP_TRAP_OFF 8'h00
`define VFL_HYP_TRAP_OFF 8'h04
`define VFL_HYP_CFG_OFF 8'h08
`define VFL_KERN_ACC_OFF 8'h0c
`define VFL_LEN_K_OFF 8'h10
`define VFL_LEN_H_OFF 8'h14
`define VFL_LEN_T_OFF 8'h18
`define VFL_CTX_OFF 8'h1c
`define VFL_SYND_OFF 8'h20
`define VFL_FADDR_OFF 8'h24
`define VFL_RADDR_OFF 8'h28
`define VFL_FFR_OFF 8'h2c
`define VFL_STAT_OFF 8'h30
`define VFL_CMD_OFF 8'h34
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VFL_TOP_EN_BIT 8
`define VFL_HYP_TRAP_BIT 8
`define VFL_EN_LO 16
`define VFL_EN_HI 17
`define VFL_E2H_BIT 34
`define VFL_E2H_REG_BIT 2
`define VFL_EC_LO 26
// ----------------------------------------------------------------
// Exception classes, widths and reset values
// ----------------------------------------------------------------
`define VFL_EC_VEC_TRAP 6'h19
`define VFL_EC_DABT_LOW 6'h24
`define VFL_EC_DABT_CUR 6'h25
`define VFL_LEN_BITS 4
`define VFL_RST_LEN 4'h0
`define VFL_RST_FFR 16'hffff
`define VFL_LANE_BITS 128
`endif

// file: common/vfl_pkg.sv
// Types shared by the vector fault and length unit
package vfl_pkg;
  typedef enum logic [3:0] {
    VFL_IDLE = 4'b0001,
    VFL_LOAD = 4'b0010,
    VFL_TRAP = 4'b0100,
    VFL_DONE = 4'b1000
  } vfl_state_t;
  typedef enum logic [1:0] {
    VFL_OP_NORMAL = 2'h0,
    VFL_OP_FIRST = 2'h1,
    VFL_OP_NOFAULT = 2'h2,
    VFL_OP_STORE = 2'h3
  } vfl_op_t;
endpackage : vfl_pkg

// file: rtl/vfl_ctrl.sv
// Vector trap, fault reporting and vector length control unit
`timescale 1ns/1ps
`include "vfl_defs.svh"
module vfl_ctrl #(
  parameter int ELEMS = 16,
  parameter int MAX_LEN = 15
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic vec_req,
  input wire logic [1:0] vec_level,
  input wire logic mem_op_valid,
  input wire logic [1:0] mem_op,
  input wire logic [ELEMS-1:0] elem_active,
  input wire logic [ELEMS-1:0] elem_fault,
  input wire logic [ELEMS-1:0] elem_suppress,
  input wire logic [31:0] fault_addr_in,
  input wire logic mem_from_lower,
  input wire logic fetch_abort_prefix,
  input wire logic fetch_abort_main,
  input wire logic [31:0] prefix_pc,
  input wire logic [31:0] main_pc,
  input wire logic prefix_changed_state,
  input wire logic async_irq,
  output logic trap_q,
  output logic data_abort_q,
  output logic restart_q,
  output logic [`VFL_LEN_BITS-1:0] eff_len_q,
  output logic [ELEMS-1:0] ffr_out_q
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic top_en_q, hyp_trap_q, e2h_q;
  logic [1:0] hyp_en_q, kern_en_q;
  logic [`VFL_LEN_BITS-1:0] len_k_q, len_h_q, len_t_q;
  logic [1:0] ctx_q;
  logic [31:0] synd_q, faddr_q, raddr_q;
  logic [ELEMS-1:0] ffr_q;
  logic [31:0] rdata_q;
  logic aw_q, w_q, bv_q, rv_q, bad_w_q, bad_r_q;
  logic awrdy_q, wrdy_q, ardy_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  vfl_pkg::vfl_state_t st_q;

  // Round a requested field down to a supported power-of-two length
  function automatic logic [`VFL_LEN_BITS-1:0] pow2_len(
    input logic [`VFL_LEN_BITS-1:0] f);
    logic [`VFL_LEN_BITS-1:0] r;
    logic [`VFL_LEN_BITS:0] n;
    r = '0;
    n = {1'b0, f} + 5'h01;
    for (int i = 0; i <= `VFL_LEN_BITS; i++) begin
      if (n[i]) begin
        r = 4'((5'h01 << i) - 5'h01);
      end
    end
    if (r > 4'(MAX_LEN)) r = 4'(MAX_LEN);
    return r;
  endfunction : pow2_len

  // ----------------------------------------------------------------
  // Trap decode
  // ----------------------------------------------------------------
  wire hyp_blk = e2h_q ? (hyp_en_q == 2'h0) : hyp_trap_q;
  wire kern_blk = (kern_en_q == 2'h0) && (vec_level == 2'h0 ||
                  vec_level == 2'h1);
  wire top_blk = !top_en_q;
  wire vec_blk = top_blk || (vec_level != 2'h3 && hyp_blk) || kern_blk;
  wire lvl_dis_k = top_blk || hyp_blk || kern_blk || ctx_q[0];
  wire lvl_dis_h = top_blk || hyp_blk || ctx_q[1];
  // Disabled level reads its length as zero except to software
  wire [3:0] len_k_eff = lvl_dis_k ? 4'h0 : len_k_q;
  wire [3:0] len_h_eff = lvl_dis_h ? 4'h0 : len_h_q;
  wire [3:0] len_t_eff = top_blk ? 4'h0 : len_t_q;
  wire [3:0] min_th = len_t_eff < len_h_eff ? len_t_eff : len_h_eff;
  wire [3:0] min_all = min_th < len_k_eff ? min_th : len_k_eff;
  wire [3:0] cur_len = vec_level == 2'h3 ? len_t_eff :
                       vec_level == 2'h2 ? min_th : min_all;
  wire [3:0] eff_len_d = pow2_len(cur_len);

  // ----------------------------------------------------------------
  // Memory fault decode
  // ----------------------------------------------------------------
  // Faults come pre-classified: translation, alignment, external, watch
  wire [ELEMS-1:0] act_fault =
    elem_fault & elem_active;
  wire [ELEMS-1:0] first_act = elem_active & (~elem_active + 1'b1);
  wire first_faults = |(first_act & elem_fault);
  wire is_nf = mem_op == vfl_pkg::VFL_OP_NOFAULT;
  wire is_ff = mem_op == vfl_pkg::VFL_OP_FIRST;
  // First element of a first-fault load cannot be suppressed
  wire [ELEMS-1:0] nf_bad = elem_active & (elem_fault |
       (is_ff ? elem_suppress & ~first_act : elem_suppress));
  wire [ELEMS-1:0] nf_low = nf_bad & (~nf_bad + 1'b1);
  wire [ELEMS-1:0] nf_clear = nf_low == '0 ? '0 : ~(nf_low - 1'b1);
  wire soft_op = is_nf || (is_ff && !first_faults);
  wire hard_fault = !soft_op && (|act_fault);
  wire [5:0] dabt_ec = mem_from_lower ? `VFL_EC_DABT_LOW : `VFL_EC_DABT_CUR;
  wire [31:0] fetch_fa = fetch_abort_prefix ? prefix_pc : main_pc;
  wire [31:0] pair_ra = prefix_changed_state ? main_pc : prefix_pc;

  // ----------------------------------------------------------------
  // AXI4-Lite decode
  // ----------------------------------------------------------------
  wire aw_take = s_axi_awvalid && !aw_q;
  wire w_take = s_axi_wvalid && !w_q;
  wire [7:0] wa = aw_take ? s_axi_awaddr : awaddr_q;
  wire [31:0] wd = w_take ? s_axi_wdata : wdata_q;
  wire wr_go = (aw_q || aw_take) && (w_q || w_take) && !bv_q;
  wire ffr_set = wr_go && wa == `VFL_CMD_OFF && wd[0];
  wire wr_ok = wa <= `VFL_CMD_OFF && wa[1:0] == 2'h0;
  wire ar_take = s_axi_arvalid && !rv_q;
  wire rd_ok = s_axi_araddr <= `VFL_CMD_OFF && s_axi_araddr[1:0] == 2'h0;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (s_axi_araddr)
      `VFL_TOP_TRAP_OFF: rd_mux[`VFL_TOP_EN_BIT] = top_en_q;
      `VFL_HYP_TRAP_OFF: rd_mux = {14'h0, hyp_en_q, 7'h0, hyp_trap_q, 8'h0};
      `VFL_HYP_CFG_OFF: rd_mux[`VFL_E2H_REG_BIT] = e2h_q;
      `VFL_KERN_ACC_OFF: rd_mux = {14'h0, kern_en_q, 16'h0};
      `VFL_LEN_K_OFF: rd_mux = {28'h0, len_k_q};
      `VFL_LEN_H_OFF: rd_mux = {28'h0, len_h_q};
      `VFL_LEN_T_OFF: rd_mux = {28'h0, len_t_q};
      `VFL_CTX_OFF: rd_mux = {30'h0, ctx_q};
      `VFL_SYND_OFF: rd_mux = synd_q;
      `VFL_FADDR_OFF: rd_mux = faddr_q;
      `VFL_RADDR_OFF: rd_mux = raddr_q;
      `VFL_FFR_OFF: rd_mux = 32'(ffr_q);
      `VFL_STAT_OFF: rd_mux = {24'h0, st_q, eff_len_q};
      default: rd_mux = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bv_q <= 1'b0;
      bad_w_q <= 1'b0;
      awrdy_q <= 1'b1;
      wrdy_q <= 1'b1;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
    end else if (ce) begin
      if (aw_take) awaddr_q <= s_axi_awaddr;
      if (w_take) wdata_q <= s_axi_wdata;
      aw_q <= wr_go ? 1'b0 : (aw_q || aw_take);
      w_q <= wr_go ? 1'b0 : (w_q || w_take);
      // Ready kept in its own flop so the port is registered
      awrdy_q <= wr_go || !(aw_q || aw_take);
      wrdy_q <= wr_go || !(w_q || w_take);
      if (wr_go) begin
        bv_q <= 1'b1;
        bad_w_q <= !wr_ok;
      end else if (s_axi_bready) begin
        bv_q <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rv_q <= 1'b0;
      bad_r_q <= 1'b0;
      rdata_q <= 32'h0;
      ardy_q <= 1'b1;
    end else if (ce) begin
      if (ar_take) begin
        rv_q <= 1'b1;
        rdata_q <= rd_mux;
        ardy_q <= 1'b0;
        bad_r_q <= !rd_ok;
      end else if (s_axi_rready) begin
        rv_q <= 1'b0;
        ardy_q <= 1'b1;
      end
    end
  end
  // Ready is held low once a beat is parked, which stalls the master
  always_comb begin
    s_axi_awready = awrdy_q;
    s_axi_wready = wrdy_q;
    s_axi_bvalid = bv_q;
    s_axi_bresp = bad_w_q ? 2'h2 : 2'h0;
    s_axi_arready = ardy_q;
    s_axi_rvalid = rv_q;
    s_axi_rdata = rdata_q;
    s_axi_rresp = bad_r_q ? 2'h2 : 2'h0;
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      top_en_q <= 1'b0;
      hyp_trap_q <= 1'b1;
      hyp_en_q <= 2'h0;
      e2h_q <= 1'b0;
      kern_en_q <= 2'h0;
      len_k_q <= `VFL_RST_LEN;
      len_h_q <= `VFL_RST_LEN;
      len_t_q <= `VFL_RST_LEN;
      ctx_q <= 2'h0;
    end else if (ce && wr_go) begin
      unique case (wa)
        `VFL_TOP_TRAP_OFF: top_en_q <= wd[`VFL_TOP_EN_BIT];
        `VFL_HYP_TRAP_OFF: begin
          hyp_trap_q <= wd[`VFL_HYP_TRAP_BIT];
          hyp_en_q <= wd[`VFL_EN_HI:`VFL_EN_LO];
        end
        `VFL_HYP_CFG_OFF: e2h_q <= wd[`VFL_E2H_REG_BIT];
        `VFL_KERN_ACC_OFF: kern_en_q <= wd[`VFL_EN_HI:`VFL_EN_LO];
        // Stored exactly as written; rounding happens on use
        `VFL_LEN_K_OFF: len_k_q <= wd[3:0];
        `VFL_LEN_H_OFF: len_h_q <= wd[3:0];
        `VFL_LEN_T_OFF: len_t_q <= wd[3:0];
        `VFL_CTX_OFF: ctx_q <= wd[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Exception state machine
  // ----------------------------------------------------------------
  wire pair_abort = fetch_abort_prefix || fetch_abort_main;
  vfl_pkg::vfl_state_t st_d;
  always_comb begin
    st_d = vfl_pkg::VFL_IDLE;
    unique case (st_q)
      vfl_pkg::VFL_IDLE:
        st_d = (vec_req && vec_blk) ? vfl_pkg::VFL_TRAP :
               mem_op_valid ? vfl_pkg::VFL_LOAD : vfl_pkg::VFL_IDLE;
      vfl_pkg::VFL_LOAD: st_d = vfl_pkg::VFL_DONE;
      vfl_pkg::VFL_TRAP: st_d = vfl_pkg::VFL_DONE;
      vfl_pkg::VFL_DONE: st_d = vfl_pkg::VFL_IDLE;
      default: st_d = vfl_pkg::VFL_IDLE;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= vfl_pkg::VFL_IDLE;
      trap_q <= 1'b0;
      data_abort_q <= 1'b0;
      restart_q <= 1'b0;
      synd_q <= 32'h0;
      faddr_q <= 32'h0;
      raddr_q <= 32'h0;
      eff_len_q <= `VFL_RST_LEN;
    end else if (ce) begin
      st_q <= st_d;
      // Datapath hides lanes past this length
      eff_len_q <= eff_len_d;
      trap_q <= st_q == vfl_pkg::VFL_IDLE && vec_req && vec_blk;
      data_abort_q <= mem_op_valid &&
                      hard_fault;
      // Whole instruction reissued; no partial progress kept
      restart_q <= async_irq || (mem_op_valid && hard_fault);
      if (st_q == vfl_pkg::VFL_IDLE && vec_req && vec_blk) begin
        synd_q <= {`VFL_EC_VEC_TRAP, 26'h0};
      end else if (mem_op_valid && hard_fault) begin
        synd_q <= {dabt_ec, 26'h0};
        faddr_q <= fault_addr_in;
      end else if (pair_abort) begin
        synd_q <= {`VFL_EC_DABT_CUR, 26'h0};
        faddr_q <= fetch_fa;
        raddr_q <= pair_ra;
      end
    end
  end

  // ----------------------------------------------------------------
  // First-fault predicate
  // ----------------------------------------------------------------
  // Loads only clear bits so the register stays true then false
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ffr_q <= ELEMS'(`VFL_RST_FFR);
    end else if (ce) begin
      if (mem_op_valid && soft_op) begin
        ffr_q <= ffr_q & ~nf_clear;
      end else if (ffr_set) begin
        ffr_q <= '1;
      end
    end
  end
  // Datapath zeroes or keeps lanes whose bit is false
  always_ff @(posedge aclk) begin
    if (!aresetn) ffr_out_q <= ELEMS'(`VFL_RST_FFR);
    else if (ce) ffr_out_q <= ffr_q;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_hard_fault;
    mem_op_valid && hard_fault;
  endsequence
  a_abort_class: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !(st_q == vfl_pkg::VFL_IDLE && vec_req && vec_blk) ##0 s_hard_fault
    |=> data_abort_q && synd_q[31:26] == $past(dabt_ec))
    else $error("data abort class wrong");
  a_trap_class: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && st_q == vfl_pkg::VFL_IDLE && vec_req && vec_blk
    |=> trap_q && synd_q[31:26] == `VFL_EC_VEC_TRAP)
    else $error("trap class wrong");
  a_nofault_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && mem_op_valid && is_nf |=> !data_abort_q)
    else $error("non-fault load aborted");
  a_ffr_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && mem_op_valid && soft_op && !ffr_set |=> (ffr_q & $past(nf_clear)) == '0)
    else $error("predicate not cleared");
  a_ffr_only_clr: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && mem_op_valid && soft_op |=> (ffr_q & ~$past(ffr_q)) == '0)
    else $error("load set a predicate bit");
  a_len_pow2: assert property (@(posedge aclk) disable iff (!aresetn)
    ((eff_len_q + 4'h1) & eff_len_q) == 4'h0 || eff_len_q == 4'(MAX_LEN))
    else $error("length not power of two");
  a_len_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && top_blk |=> eff_len_q == 4'h0)
    else $error("disabled length not zero");
  a_ff_first: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && mem_op_valid && is_ff && first_faults && !vec_req |=> data_abort_q)
    else $error("first element fault lost");
  a_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && async_irq |=> restart_q)
    else $error("interrupt without restart");
endmodule : vfl_ctrl

// file: testbench/vfl_ctrl_bench.sv
// Self-checking bench for the vector trap, fault and length unit
`timescale 1ns/1ps
`include "vfl_defs.svh"
module vfl_ctrl_bench;
  logic aclk, aresetn, ce, vec_req, async_irq;
  logic [1:0] vec_level, s_axi_bresp, s_axi_rresp, mem_op;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, trap_q, data_abort_q, restart_q;
  logic [`VFL_LEN_BITS-1:0] eff_len_q;
  logic [15:0] ffr_out_q, elem_active, elem_fault, elem_suppress;
  logic [31:0] fault_addr_in, prefix_pc, main_pc;
  logic mem_op_valid, mem_from_lower, fetch_abort_prefix;
  logic fetch_abort_main, prefix_changed_state;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  vfl_ctrl #(.ELEMS(16), .MAX_LEN(15)) DUT (.aclk, .aresetn, .ce,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .vec_req, .vec_level, .mem_op_valid, .mem_op,
    .elem_active, .elem_fault, .elem_suppress, .fault_addr_in,
    .mem_from_lower, .fetch_abort_prefix, .fetch_abort_main, .prefix_pc,
    .main_pc, .prefix_changed_state, .async_irq, .trap_q, .data_abort_q,
    .restart_q, .eff_len_q, .ffr_out_q);
  vfl_mem_model #(.ELEMS(16)) u_mem (.aclk, .mem_op_valid, .mem_op,
    .elem_active, .elem_fault, .elem_suppress, .fault_addr_in,
    .mem_from_lower, .fetch_abort_prefix, .fetch_abort_main, .prefix_pc,
    .main_pc, .prefix_changed_state);
  // ----------------------------------------------------------------
  // Clock, watchdog and access tasks
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
    input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk(32'(s_axi_rresp), 32'(er));
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] m);
    rd(a, 2'h0);
    chk(d & m, e);
  endtask : rdc
  task automatic vec_try(input logic e);
    vec_req <= 1'b1;
    @(posedge aclk);
    vec_req <= 1'b0;
    @(posedge aclk);
    chk(32'(trap_q), 32'(e));
  endtask : vec_try
  task automatic mem(input logic [1:0] op, input logic [15:0] act,
    input logic [15:0] flt, input logic [15:0] sup, input logic lo,
    input logic ab, input int lag);
    u_mem.mem_access(op, act, flt, sup, lo, lag);
    @(posedge aclk);
    chk(32'(data_abort_q), 32'(ab));
    chk(32'(restart_q), 32'(ab));
  endtask : mem
  function automatic logic [3:0] lenf(input int v);
    int p;
    p = 1;
    while (p * 2 <= v + 1) p = p * 2;
    return 4'(p - 1);
  endfunction : lenf
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {aresetn, vec_req, async_irq, s_axi_awvalid, s_axi_wvalid} = 5'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    ce = 1'b1;
    vec_level = 2'h1;
    s_axi_wstrb = 4'hf;
    tick(3);
    aresetn <= 1'b1;
    chk(32'(ffr_out_q), 32'hffff);
    rdc(`VFL_HYP_TRAP_OFF, 32'h100, 32'h30100);
    rd(8'h40, 2'h2);
    chk(d, 32'h0);
    wr(8'h40, 32'h1, 2'h2);
    $display("test reset done");
    vec_try(1'b1);
    rdc(`VFL_SYND_OFF, 32'h64000000, 32'hfc000000);
    wr(`VFL_TOP_TRAP_OFF, 32'h100, 2'h0);
    vec_try(1'b1);
    wr(`VFL_HYP_TRAP_OFF, 32'h0, 2'h0);
    vec_try(1'b1);
    wr(`VFL_KERN_ACC_OFF, 32'h30000, 2'h0);
    vec_try(1'b0);
    wr(`VFL_HYP_CFG_OFF, 32'h4, 2'h0);
    vec_try(1'b1);
    wr(`VFL_HYP_TRAP_OFF, 32'h30100, 2'h0);
    vec_try(1'b0);
    $display("test trap done");
    wr(`VFL_LEN_T_OFF, 32'hf, 2'h0);
    wr(`VFL_LEN_H_OFF, 32'hf, 2'h0);
    for (int v = 0; v < 16; v++) begin
      wr(`VFL_LEN_K_OFF, 32'(v), 2'h0);
      tick(1);
      chk(32'(eff_len_q), 32'(lenf(v)));
      rdc(`VFL_LEN_K_OFF, 32'(v), 32'hf);
    end
    wr(`VFL_LEN_H_OFF, 32'h2, 2'h0);
    tick(1);
    chk(32'(eff_len_q), 32'h1);
    wr(`VFL_KERN_ACC_OFF, 32'h0, 2'h0);
    tick(1);
    chk(32'(eff_len_q), 32'h0);
    wr(`VFL_KERN_ACC_OFF, 32'h30000, 2'h0);
    wr(`VFL_CTX_OFF, 32'h1, 2'h0);
    tick(1);
    chk(32'(eff_len_q), 32'h0);
    wr(`VFL_CTX_OFF, 32'h0, 2'h0);
    tick(1);
    chk(32'(eff_len_q), 32'h1);
    $display("test length done");
    for (int lo = 0; lo < 2; lo++) begin
      mem(2'h0, 16'h00f0, 16'h0060, 16'h0, lo[0], 1'b1, lo * 3);
      rdc(`VFL_SYND_OFF, lo ? 32'h90000000 : 32'h94000000, 32'hfc000000);
      rdc(`VFL_FADDR_OFF, 32'h1014, '1);
    end
    mem(2'h0, 16'h00f0, 16'h0f00, 16'h0, 1'b0, 1'b0, 0);
    mem(2'h3, 16'hffff, 16'h8001, 16'h0, 1'b0, 1'b1, 0);
    rdc(`VFL_FADDR_OFF, 32'h1000, '1);
    wr(`VFL_CMD_OFF, 32'h1, 2'h0);
    mem(2'h2, 16'hffff, 16'h0100, 16'h0, 1'b1, 1'b0, 0);
    tick(1);
    chk(32'(ffr_out_q), 32'h00ff);
    mem(2'h2, 16'hffff, 16'h0, 16'h0040, 1'b1, 1'b0, 2);
    mem(2'h2, 16'hffff, 16'h0, 16'h0, 1'b1, 1'b0, 0);
    rdc(`VFL_FFR_OFF, 32'h003f, 32'hffff);
    rdc(`VFL_SYND_OFF, 32'h94000000, 32'hfc000000);
    rdc(`VFL_FADDR_OFF, 32'h1000, '1);
    wr(`VFL_CMD_OFF, 32'h1, 2'h0);
    tick(1);
    chk(32'(ffr_out_q), 32'hffff);
    mem(2'h1, 16'hfffc, 16'h0004, 16'h0, 1'b1, 1'b1, 0);
    rdc(`VFL_FADDR_OFF, 32'h1008, '1);
    wr(`VFL_CMD_OFF, 32'h1, 2'h0);
    mem(2'h1, 16'hfffc, 16'h0400, 16'h0, 1'b1, 1'b0, 1);
    tick(1);
    chk(32'(ffr_out_q), 32'h03ff);
    $display("test fault done");
    u_mem.fetch_pair(1'b0, 1'b1, 1'b0, 32'h3000, 32'h3004);
    tick(1);
    rdc(`VFL_FADDR_OFF, 32'h3004, '1);
    rdc(`VFL_RADDR_OFF, 32'h3000, '1);
    u_mem.fetch_pair(1'b1, 1'b1, 1'b1, 32'h3000, 32'h3004);
    tick(1);
    rdc(`VFL_FADDR_OFF, 32'h3000, '1);
    rdc(`VFL_RADDR_OFF, 32'h3004, '1);
    async_irq <= 1'b1;
    @(posedge aclk);
    async_irq <= 1'b0;
    @(posedge aclk);
    chk(32'(restart_q), 32'h1);
    // Clock enable low must freeze the restart flag
    {ce, async_irq} <= 2'h1;
    @(posedge aclk);
    {ce, async_irq} <= 2'h2;
    @(posedge aclk);
    chk(32'(restart_q), 32'h0);
    $display("test prefix done");
    finish_test();
  end
endmodule : vfl_ctrl_bench

// file: testbench/vfl_mem_model.sv
// Behavioural memory system and fetch side facing the fault unit
`timescale 1ns/1ps
module vfl_mem_model #(
  parameter int ELEMS = 16
) (
  input wire logic aclk,
  output logic mem_op_valid,
  output logic [1:0] mem_op,
  output logic [ELEMS-1:0] elem_active,
  output logic [ELEMS-1:0] elem_fault,
  output logic [ELEMS-1:0] elem_suppress,
  output logic [31:0] fault_addr_in,
  output logic mem_from_lower,
  output logic fetch_abort_prefix,
  output logic fetch_abort_main,
  output logic [31:0] prefix_pc,
  output logic [31:0] main_pc,
  output logic prefix_changed_state
);
  // ----------------------------------------------------------------
  // Tasks, entered just after a rising edge
  // ----------------------------------------------------------------
  initial begin
    {mem_op_valid, mem_op, mem_from_lower} = 4'h0;
    {elem_active, elem_fault, elem_suppress} = '0;
    {fault_addr_in, prefix_pc, main_pc} = 96'h0;
    {fetch_abort_prefix, fetch_abort_main, prefix_changed_state} = 3'h0;
  end
  task automatic mem_access(input logic [1:0] op,
    input logic [ELEMS-1:0] act, input logic [ELEMS-1:0] flt,
    input logic [ELEMS-1:0] sup, input logic lower, input int lag);
    logic [ELEMS-1:0] hit;
    logic [31:0] fa;
    hit = act & flt; // Only active lanes give an address
    fa = 32'h0;
    for (int i = ELEMS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        fa = 32'h1000 + 32'(i * 4);
      end
    end
    repeat (lag) @(posedge aclk);
    mem_op <= op;
    elem_active <= act;
    // Raw lane faults: the unit must drop inactive ones
    elem_fault <= flt;
    // First active lane is never dropped
    elem_suppress <= sup & act & ~(act & (~act + 1'b1));
    fault_addr_in <= fa;
    mem_from_lower <= lower;
    mem_op_valid <= 1'b1;
    @(posedge aclk);
    mem_op_valid <= 1'b0;
    // Released bus shows garbage so a late sample cannot pass
    fault_addr_in <= ~fa;
  endtask : mem_access
  task automatic fetch_pair(input logic ab_p, input logic ab_m,
    input logic chg, input logic [31:0] ppc, input logic [31:0] mpc);
    prefix_pc <= ppc;
    main_pc <= mpc;
    prefix_changed_state <= chg;
    fetch_abort_prefix <= ab_p;
    fetch_abort_main <= ab_m;
    @(posedge aclk);
    {fetch_abort_prefix, fetch_abort_main} <= 2'h0;
    prefix_pc <= ~ppc;
    main_pc <= ~mpc;
  endtask : fetch_pair
endmodule : vfl_mem_model
